/* File: src/nvm_clk_pkg.sv */
// constants and types shared by the nonvolatile clock and option register block
package nvm_clk_pkg;

   localparam int          APB_ADDR_W         = 12;
   localparam int          KEY_BYTES          = 8;
   localparam int          PRESCALE_FACTOR    = 8;
   localparam int          RATIO_W            = 6;

   // register byte offsets
   localparam logic [11:0] OFF_CLOCK_RATIO    = 12'h000;
   localparam logic [11:0] OFF_OPTION_SHADOW  = 12'h004;
   localparam logic [11:0] OFF_KEY_DATA       = 12'h008;
   localparam logic [11:0] OFF_CONTROL        = 12'h00C;
   localparam logic [11:0] OFF_COMMAND        = 12'h010;

   // clock ratio register fields
   localparam int          RATIO_LOADED_BIT   = 7;
   localparam int          RATIO_PRESCALE_BIT = 6;
   localparam int          RATIO_FIELD_LSB    = 0;
   localparam logic [7:0]  RATIO_RESET        = 8'h00;

   // option shadow register fields
   localparam int          OPT_UNLOCK_EN_BIT  = 7;
   localparam int          OPT_RELOC_OFF_BIT  = 6;
   localparam int          OPT_SEC_LSB        = 0;
   localparam logic [7:0]  OPT_USED_MASK      = 8'hC3;
   localparam logic [7:0]  OPT_RESET          = 8'h03;
   localparam logic [1:0]  SEC_UNSECURED      = 2'h2;

   // control register fields
   localparam int          CTRL_KEY_ACC_BIT   = 0;
   localparam int          CTRL_SECURE_BIT    = 1;
   localparam int          CTRL_BUSY_BIT      = 2;
   localparam int          CTRL_ACC_ERR_BIT   = 3;
   localparam int          CTRL_KEY_OK_BIT    = 4;

   // command register fields
   localparam int          CMD_PROGRAM_BIT    = 0;
   localparam int          CMD_ERASE_BIT      = 1;

   typedef struct packed {
      logic       backdoor_unlock_enable;
      logic       vector_relocate_off;
      logic [3:0] unused;
      logic [1:0] security_code;
   } option_t;

   typedef struct packed {
      logic               prescale_by_eight;
      logic [RATIO_W-1:0] clock_ratio_field;
   } ratio_t;

   typedef enum logic [3:0] {
      SEQ_IDLE  = 4'b0001,
      SEQ_ALIGN = 4'b0010,
      SEQ_PULSE = 4'b0100,
      SEQ_DONE  = 4'b1000
   } seq_state_t;

endpackage

/* File: src/nvm_timing_divider.sv */
// divider that turns the bus clock into nonvolatile timing clock enable pulses
`timescale 1ns/1ps
module nvm_timing_divider
   import nvm_clk_pkg::*;
(
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic run,
   input  wire ratio_t ratio,
   output logic      nvm_timing_tick
);

   logic [2:0]         pre_cnt_reg;
   logic [2:0]         pre_cnt_next;
   logic [RATIO_W-1:0] div_cnt_reg;
   logic [RATIO_W-1:0] div_cnt_next;
   logic               tick_reg;
   logic               tick_next;
   logic               stage_en;

   always_comb begin
      pre_cnt_next = 3'h0;
      div_cnt_next = div_cnt_reg;
      tick_next    = 1'b0;
      stage_en     = 1'b0;
      if (run) begin
         // (RULE5) optional divide by eight
         if (ratio.prescale_by_eight) begin
            pre_cnt_next = pre_cnt_reg + 3'h1;
            stage_en     = (pre_cnt_reg == 3'(PRESCALE_FACTOR - 1));
         end else begin
            stage_en     = 1'b1;
         end
         // (RULE6) divide by ratio plus one
         // (RULE21) counter issues one enable
         if (stage_en) begin
            if (div_cnt_reg >= ratio.clock_ratio_field) begin
               div_cnt_next = '0;
               tick_next    = 1'b1;
            end else begin
               div_cnt_next = div_cnt_reg + 1'b1;
            end
         end
      end else begin
         div_cnt_next = '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_cnt_reg <= 3'h0;
         div_cnt_reg <= '0;
         tick_reg    <= 1'b0;
      end else begin
         pre_cnt_reg <= pre_cnt_next;
         div_cnt_reg <= div_cnt_next;
         tick_reg    <= tick_next;
      end
   end

   assign nvm_timing_tick = tick_reg;

endmodule // nvm_timing_divider

/* File: src/flash_clock_and_option_regs.sv */
// clock ratio and option shadow registers of the nonvolatile memory controller
//
// Summary of operation
// (RULE1) first ratio write sets read-only loaded flag
// (RULE2) prescale and ratio accept one write only
// (RULE3) erase and program refused until loaded
// (RULE4) software writes ratio before any operation
// (RULE5) prescale bit selects bus clock or /8
// (RULE6) divider divides by ratio plus one
// (RULE7) software keeps timing clock 150-200 kHz
// (RULE8) operations last whole timing clock periods
// (RULE9) option shadow loaded from flash at reset
// (RULE10) option bits five to two read zero
// (RULE11) option shadow readable, writes ignored
// (RULE12) software reprograms flash then resets for change
// (RULE13) unlock enable low blocks backdoor unlock
// (RULE14) eight matching key bytes unlock until reset
// (RULE15) key writes accepted only from secure firmware
// (RULE16) relocate-off bit disables vector redirection
// (RULE17) security code blocks unsecured memory access
// (RULE18) code one-zero unsecured, others secure
// (RULE19) key match or blank check unsecures
// (RULE20) blocked write ignored, blocked read zero
// (RULE21) bus clock counter makes timing enables
`timescale 1ns/1ps
module flash_clock_and_option_regs
   import nvm_clk_pkg::*;
#(
   parameter int PROG_PULSES  = 9,
   parameter int ERASE_PULSES = 4000
)
(
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [APB_ADDR_W-1:0] paddr,
   input  wire logic [31:0]           pwdata,
   input  wire logic [2:0]            pprot,
   output logic [31:0]                prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic [7:0]            stored_option_byte,
   input  wire logic [63:0]           stored_unlock_key,
   input  wire logic                  blank_check_pass,
   input  wire logic                  mem_access_unsecured,
   input  wire logic                  mem_wr_req,
   input  wire logic [7:0]            mem_rdata_raw,
   output logic                       mem_wr_allow,
   output logic [7:0]                 mem_rdata,
   output logic                       secure_state,
   output logic                       vector_redirect_en,
   output logic                       nvm_timing_tick,
   output logic                       nvm_timing_pulse,
   output logic                       nvm_op_erase,
   output logic                       nvm_op_done
);

   ratio_t     ratio_reg;
   ratio_t     ratio_next;
   logic       loaded_reg;
   logic       loaded_next;
   option_t    opt_reg;
   option_t    opt_next;
   logic       load_pend_reg;
   logic       key_acc_reg;
   logic       key_acc_next;
   logic [3:0] key_idx_reg;
   logic [3:0] key_idx_next;
   logic       key_ok_reg;
   logic       key_ok_next;
   logic       acc_err_reg;
   logic       acc_err_next;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic [7:0] mem_rdata_reg;
   logic [7:0] mem_rdata_next;

   seq_state_t  state_reg;
   seq_state_t  state_next;
   logic [15:0] pulse_cnt_reg;
   logic [15:0] pulse_cnt_next;
   logic [15:0] pulse_target;
   logic        erase_reg;
   logic        erase_next;
   logic        pulse_reg;
   logic        pulse_next;
   logic        done_reg;
   logic        done_next;

   logic        setup;
   logic        wr_access;
   logic        addr_ok;
   logic        secure;
   logic        secure_src;
   logic        cmd_any;
   logic        cmd_start;
   logic        cmd_refused;
   logic        key_match;
   logic        tick;
   logic [7:0]  key_byte;
   logic [31:0] read_mux;

   assign setup     = psel && !penable;
   assign wr_access = psel && penable && pwrite && addr_ok;
   assign addr_ok   = (paddr == OFF_CLOCK_RATIO) || (paddr == OFF_OPTION_SHADOW) ||
                      (paddr == OFF_KEY_DATA) || (paddr == OFF_CONTROL) ||
                      (paddr == OFF_COMMAND);
   assign pready    = 1'b1;
   assign pslverr   = psel && penable && !addr_ok;
   assign prdata    = prdata_reg;

   // (RULE18) only one-zero is unsecured
   assign secure     = (opt_reg.security_code != SEC_UNSECURED);
   // (RULE15) secure firmware only, not debug
   assign secure_src = !pprot[1];
   assign key_byte   = stored_unlock_key[8*key_idx_reg[2:0] +: 8];
   assign key_match  = (pwdata[7:0] == key_byte);

   // (RULE3) operations gated by loaded flag
   assign cmd_any     = wr_access && (paddr == OFF_COMMAND) &&
                        (pwdata[CMD_PROGRAM_BIT] || pwdata[CMD_ERASE_BIT]);
   assign cmd_start   = cmd_any && loaded_reg && (state_reg == SEQ_IDLE) &&
                        (pwdata[CMD_PROGRAM_BIT] != pwdata[CMD_ERASE_BIT]);
   assign cmd_refused = cmd_any && !cmd_start;

   always_comb begin
      read_mux = 32'h0000_0000;
      case (paddr)
         OFF_CLOCK_RATIO: begin
            read_mux[RATIO_LOADED_BIT]   = loaded_reg;
            read_mux[RATIO_PRESCALE_BIT:RATIO_FIELD_LSB] = ratio_reg;
         end
         // (RULE10) unused bits forced zero
         OFF_OPTION_SHADOW: begin
            read_mux[7:0] = opt_reg & OPT_USED_MASK;
         end
         OFF_CONTROL: begin
            read_mux[CTRL_KEY_ACC_BIT] = key_acc_reg;
            read_mux[CTRL_SECURE_BIT]  = secure;
            read_mux[CTRL_BUSY_BIT]    = (state_reg != SEQ_IDLE);
            read_mux[CTRL_ACC_ERR_BIT] = acc_err_reg;
            read_mux[CTRL_KEY_OK_BIT]  = key_ok_reg;
         end
         default: begin
            read_mux = 32'h0000_0000;
         end
      endcase
   end

   always_comb begin
      ratio_next   = ratio_reg;
      loaded_next  = loaded_reg;
      opt_next     = opt_reg;
      key_acc_next = key_acc_reg;
      key_idx_next = key_idx_reg;
      key_ok_next  = key_ok_reg;
      acc_err_next = acc_err_reg;
      prdata_next  = prdata_reg;
      if (setup) begin
         prdata_next = read_mux;
      end
      // (RULE9) shadow copy of stored option byte
      if (load_pend_reg) begin
         opt_next = option_t'(stored_option_byte & OPT_USED_MASK);
      end
      // (RULE1) any write sets loaded flag
      // (RULE2) fields written once only
      if (wr_access && (paddr == OFF_CLOCK_RATIO)) begin
         if (!loaded_reg) begin
            ratio_next = ratio_t'(pwdata[RATIO_PRESCALE_BIT:RATIO_FIELD_LSB]);
         end
         loaded_next = 1'b1;
      end
      // (RULE11) option shadow has no write path
      // (RULE14) key bytes compared in order
      if (wr_access && (paddr == OFF_KEY_DATA) && key_acc_reg && secure_src) begin
         key_ok_next = key_ok_reg && !key_idx_reg[3] && key_match;
         if (!key_idx_reg[3]) begin
            key_idx_next = key_idx_reg + 4'h1;
         end
      end
      if (wr_access && (paddr == OFF_CONTROL) && secure_src) begin
         key_acc_next = pwdata[CTRL_KEY_ACC_BIT];
         if (pwdata[CTRL_KEY_ACC_BIT] && !key_acc_reg) begin
            key_idx_next = 4'h0;
            key_ok_next  = 1'b1;
         end
         // (RULE13) unlock only with enable bit
         // (RULE19) key match unsecures
         if (key_acc_reg && !pwdata[CTRL_KEY_ACC_BIT] && key_ok_reg &&
             (key_idx_reg == 4'(KEY_BYTES)) && opt_reg.backdoor_unlock_enable) begin
            opt_next.security_code = SEC_UNSECURED;
         end
         if (pwdata[CTRL_ACC_ERR_BIT]) begin
            acc_err_next = 1'b0;
         end
      end
      // (RULE19) blank check unsecures
      if (blank_check_pass) begin
         opt_next.security_code = SEC_UNSECURED;
      end
      // (RULE3) refused command flags error
      if (cmd_refused) begin
         acc_err_next = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ratio_reg     <= ratio_t'(RATIO_RESET[RATIO_PRESCALE_BIT:RATIO_FIELD_LSB]);
         loaded_reg    <= RATIO_RESET[RATIO_LOADED_BIT];
         opt_reg       <= option_t'(OPT_RESET);
         load_pend_reg <= 1'b1;
         key_acc_reg   <= 1'b0;
         key_idx_reg   <= 4'h0;
         key_ok_reg    <= 1'b0;
         acc_err_reg   <= 1'b0;
         prdata_reg    <= 32'h0000_0000;
      end else begin
         ratio_reg     <= ratio_next;
         loaded_reg    <= loaded_next;
         opt_reg       <= opt_next;
         load_pend_reg <= 1'b0;
         key_acc_reg   <= key_acc_next;
         key_idx_reg   <= key_idx_next;
         key_ok_reg    <= key_ok_next;
         acc_err_reg   <= acc_err_next;
         prdata_reg    <= prdata_next;
      end
   end

   // (RULE17) block unsecured memory access
   // (RULE20) writes dropped, reads zero
   assign mem_wr_allow = mem_wr_req && !(secure && mem_access_unsecured);

   always_comb begin
      mem_rdata_next = mem_rdata_raw;
      if (secure && mem_access_unsecured) begin
         mem_rdata_next = 8'h00;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_rdata_reg <= 8'h00;
      end else begin
         mem_rdata_reg <= mem_rdata_next;
      end
   end

   assign mem_rdata          = mem_rdata_reg;
   assign secure_state       = secure;
   // (RULE16) redirection off when bit set
   assign vector_redirect_en = !opt_reg.vector_relocate_off;

   nvm_timing_divider u_divider (
      .pclk            (pclk),
      .presetn         (presetn),
      .run             (loaded_reg),
      .ratio           (ratio_reg),
      .nvm_timing_tick (tick)
   );

   assign nvm_timing_tick = tick;
   assign pulse_target    = erase_reg ? 16'(ERASE_PULSES) : 16'(PROG_PULSES);

   // (RULE8) whole timing periods per operation
   always_comb begin
      state_next     = state_reg;
      pulse_cnt_next = pulse_cnt_reg;
      erase_next     = erase_reg;
      pulse_next     = pulse_reg;
      done_next      = 1'b0;
      case (state_reg)
         SEQ_IDLE: begin
            if (cmd_start) begin
               state_next     = SEQ_ALIGN;
               pulse_cnt_next = 16'h0000;
               erase_next     = pwdata[CMD_ERASE_BIT];
            end
         end
         SEQ_ALIGN: begin
            if (tick) begin
               state_next = SEQ_PULSE;
               pulse_next = 1'b1;
            end
         end
         SEQ_PULSE: begin
            if (tick) begin
               pulse_cnt_next = pulse_cnt_reg + 16'h0001;
               if (pulse_cnt_next >= pulse_target) begin
                  state_next = SEQ_DONE;
                  pulse_next = 1'b0;
               end
            end
         end
         SEQ_DONE: begin
            state_next = SEQ_IDLE;
            done_next  = 1'b1;
         end
         default: begin
            state_next = SEQ_IDLE;
            pulse_next = 1'b0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg     <= SEQ_IDLE;
         pulse_cnt_reg <= 16'h0000;
         erase_reg     <= 1'b0;
         pulse_reg     <= 1'b0;
         done_reg      <= 1'b0;
      end else begin
         state_reg     <= state_next;
         pulse_cnt_reg <= pulse_cnt_next;
         erase_reg     <= erase_next;
         pulse_reg     <= pulse_next;
         done_reg      <= done_next;
      end
   end

   assign nvm_timing_pulse = pulse_reg;
   assign nvm_op_erase     = erase_reg;
   assign nvm_op_done      = done_reg;

endmodule // flash_clock_and_option_regs

/* File: tb/flash_regs_chk_sva.sv */
// checker watching the ports of the clock ratio and option register block
`timescale 1ns/1ps
module flash_regs_chk
   import nvm_clk_pkg::*;
#(
   parameter int PROG_PULSES  = 9,
   parameter int ERASE_PULSES = 4000
)
(
   input wire logic                  pclk,
   input wire logic                  presetn,
   input wire logic                  psel,
   input wire logic                  penable,
   input wire logic                  pwrite,
   input wire logic [APB_ADDR_W-1:0] paddr,
   input wire logic                  pready,
   input wire logic                  blank_check_pass,
   input wire logic                  mem_access_unsecured,
   input wire logic                  mem_wr_req,
   input wire logic [7:0]            mem_rdata_raw,
   input wire logic                  mem_wr_allow,
   input wire logic [7:0]            mem_rdata,
   input wire logic                  secure_state,
   input wire logic                  nvm_timing_tick,
   input wire logic                  nvm_timing_pulse,
   input wire logic                  nvm_op_erase,
   input wire logic                  nvm_op_done
);
   logic        seen_reg;
   logic        seen_next;
   logic [15:0] ticks_reg;
   logic [15:0] ticks_next;
   always_comb begin
      seen_next  = seen_reg | (psel & penable & pready & pwrite & (paddr == OFF_CLOCK_RATIO));
      ticks_next = nvm_timing_pulse ? ticks_reg + 16'(nvm_timing_tick) : 16'h0000;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seen_reg  <= 1'b0;
         ticks_reg <= 16'h0000;
      end else begin
         seen_reg  <= seen_next;
         ticks_reg <= ticks_next;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_pulse_start;
      $rose(nvm_timing_pulse);
   endsequence
   sequence s_pulse_end;
      $fell(nvm_timing_pulse);
   endsequence
   AST_WR_BLOCK: assert property (
      mem_wr_allow == (mem_wr_req && !(secure_state && mem_access_unsecured)))
      else $error("blocked write passed");
   AST_RD_BLOCK: assert property (
      1'b1 |=> mem_rdata == (($past(secure_state) && $past(mem_access_unsecured)) ?
                             8'h00 : $past(mem_rdata_raw)))
      else $error("read data not blocked");
   AST_LOAD_GATE: assert property (s_pulse_start |-> seen_reg)
      else $error("operation before ratio write");
   AST_DIV_RUN: assert property (nvm_timing_tick |-> seen_reg)
      else $error("tick before ratio write");
   AST_PULSE_ALIGN: assert property (s_pulse_start |-> $past(nvm_timing_tick))
      else $error("pulse not aligned to tick");
   AST_PULSE_COUNT: assert property (
      s_pulse_end |-> ticks_reg == (nvm_op_erase ? 16'(ERASE_PULSES) : 16'(PROG_PULSES)))
      else $error("wrong pulse count");
   AST_DONE_AFTER: assert property (s_pulse_end |-> ##[0:1] nvm_op_done)
      else $error("no done after pulse");
   AST_DONE_ONE: assert property (nvm_op_done |=> !nvm_op_done)
      else $error("done longer than one cycle");
   AST_BLANK_UNSEC: assert property (blank_check_pass |-> ##[1:2] !secure_state)
      else $error("blank check did not unsecure");
endmodule // flash_regs_chk

bind flash_clock_and_option_regs flash_regs_chk #(
   .PROG_PULSES (PROG_PULSES),
   .ERASE_PULSES(ERASE_PULSES)
) i_flash_regs_chk (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready, .blank_check_pass,
   .mem_access_unsecured, .mem_wr_req, .mem_rdata_raw, .mem_wr_allow, .mem_rdata,
   .secure_state, .nvm_timing_tick, .nvm_timing_pulse, .nvm_op_erase, .nvm_op_done
);

/* File: tb/testbench.sv */
// self-checking bench for the clock ratio and option register block
`timescale 1ns/1ps
module testbench
   import nvm_clk_pkg::*;
;
   localparam logic [63:0] KEY     = 64'h0123_4567_89AB_CDEF;
   localparam int          PROG_N  = 3;
   localparam int          ERASE_N = 5;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [2:0]  pprot;
   logic [7:0]  stored_option_byte, mem_rdata_raw, mem_rdata;
   logic [63:0] stored_unlock_key;
   logic        blank_check_pass, mem_access_unsecured, mem_wr_req, mem_wr_allow;
   logic        secure_state, vector_redirect_en, nvm_timing_tick, nvm_timing_pulse;
   logic        nvm_op_erase, nvm_op_done;
   int          n_mismatch, samples_checked, n;

   flash_clock_and_option_regs #(
      .PROG_PULSES (PROG_N),
      .ERASE_PULSES(ERASE_N)
   ) i_flash_clock_and_option_regs (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pprot, .prdata,
      .pready, .pslverr, .stored_option_byte, .stored_unlock_key, .blank_check_pass,
      .mem_access_unsecured, .mem_wr_req, .mem_rdata_raw, .mem_wr_allow, .mem_rdata,
      .secure_state, .vector_redirect_en, .nvm_timing_tick, .nvm_timing_pulse,
      .nvm_op_erase, .nvm_op_done
   );

   always #5 pclk = ~pclk;

   task report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task chk(input logic [31:0] g, input logic [31:0] x);
      samples_checked++;
      if (g !== x) begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask

   task cyc;
      @(posedge pclk);
      #1;
   endtask

   task do_reset;
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
   endtask

   // apb transfer, held until pready is sampled high
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] rd, output logic err);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 16) n_mismatch++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, r, e);
   endtask

   task rdc(input logic [11:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0000_0000, r, e);
      chk(r, x);
   endtask

   task tick_gap(output int g);
      int i;
      cyc();
      for (i = 0; i < 1000 && nvm_timing_tick !== 1'b1; i++) cyc();
      cyc();
      g = 1;
      while (nvm_timing_tick !== 1'b1 && g < 1000) begin
         cyc();
         g++;
      end
   endtask

   task run_op(input logic [31:0] cmd, input int np, input logic er);
      int t, i;
      t = 0;
      wr(OFF_COMMAND, cmd);
      for (i = 0; i < 2000 && nvm_op_done !== 1'b1; i++) begin
         cyc();
         if (nvm_timing_pulse === 1'b1 && nvm_timing_tick === 1'b1) t++;
      end
      chk(32'(nvm_op_done), 32'h0000_0001);
      chk(32'(t), 32'(np));
      chk(32'(nvm_op_erase), 32'(er));
   endtask

   task mem_chk(input logic u, input logic xa, input logic [7:0] xr);
      @(posedge pclk);
      mem_access_unsecured <= u;
      mem_wr_req <= 1'b1;
      mem_rdata_raw <= 8'hA5;
      cyc();
      chk(32'(mem_wr_allow), 32'(xa));
      chk(32'(mem_rdata), 32'(xr));
   endtask

   // key entry from the given source; byte bad is corrupted
   task key_try(input logic [2:0] prot, input int bad);
      int i;
      pprot <= prot;
      wr(OFF_CONTROL, 32'h0000_0001);
      for (i = 0; i < KEY_BYTES; i++) begin
         wr(OFF_KEY_DATA, {24'h0, KEY[8*i+:8] ^ ((i == bad) ? 8'h01 : 8'h00)});
      end
      wr(OFF_CONTROL, 32'h0000_0000);
      pprot <= 3'h0;
      cyc();
      cyc();
   endtask

   initial begin
      repeat (20000) @(posedge pclk);
      n_mismatch++;
      report_and_stop();
   end

   initial begin
      pclk = 0;
      presetn = 0;
      {psel, penable, pwrite, paddr, pwdata, pprot} = '0;
      {blank_check_pass, mem_access_unsecured, mem_wr_req, mem_rdata_raw} = '0;
      stored_option_byte = 8'hFD;
      stored_unlock_key = KEY;
      n_mismatch = 0;
      samples_checked = 0;
      do_reset();
      rdc(OFF_OPTION_SHADOW, 32'h0000_00C1);
      chk(32'(vector_redirect_en), 32'h0000_0000);
      chk(32'(secure_state), 32'h0000_0001);
      wr(OFF_OPTION_SHADOW, 32'h0000_0000);
      rdc(OFF_OPTION_SHADOW, 32'h0000_00C1);
      rdc(OFF_CLOCK_RATIO, 32'h0000_0000);
      wr(OFF_COMMAND, 32'h0000_0001);
      repeat (8) cyc();
      chk(32'(nvm_timing_pulse), 32'h0000_0000);
      rdc(OFF_CONTROL, 32'h0000_000A);
      wr(OFF_CONTROL, 32'h0000_0008);
      wr(OFF_CLOCK_RATIO, 32'h0000_0002);
      wr(OFF_CLOCK_RATIO, 32'h0000_007F);
      rdc(OFF_CLOCK_RATIO, 32'h0000_0082);
      tick_gap(n);
      chk(32'(n), 32'h0000_0003);
      run_op(32'h0000_0001, PROG_N, 1'b0);
      run_op(32'h0000_0002, ERASE_N, 1'b1);
      mem_chk(1'b1, 1'b0, 8'h00);
      mem_chk(1'b0, 1'b1, 8'hA5);
      key_try(3'h2, -1);
      chk(32'(secure_state), 32'h0000_0001);
      key_try(3'h0, 3);
      chk(32'(secure_state), 32'h0000_0001);
      key_try(3'h0, -1);
      chk(32'(secure_state), 32'h0000_0000);
      rdc(OFF_OPTION_SHADOW, 32'h0000_00C2);
      mem_chk(1'b1, 1'b1, 8'hA5);
      apb(1'b0, 12'hFFC, 32'h0000_0000, r, e);
      chk(r, 32'h0000_0000);
      chk(32'(e), 32'h0000_0001);
      stored_option_byte <= 8'h01;
      do_reset();
      rdc(OFF_OPTION_SHADOW, 32'h0000_0001);
      chk(32'(vector_redirect_en), 32'h0000_0001);
      wr(OFF_CLOCK_RATIO, 32'h0000_007E);
      tick_gap(n);
      chk(32'(n), 32'h0000_01F8);
      key_try(3'h0, -1);
      chk(32'(secure_state), 32'h0000_0001);
      @(posedge pclk);
      blank_check_pass <= 1'b1;
      @(posedge pclk);
      blank_check_pass <= 1'b0;
      cyc();
      chk(32'(secure_state), 32'h0000_0000);
      report_and_stop();
   end
endmodule // testbench
